/* verilog/gpsc_top.sv */
// Pipe sync control: parse stall, outstanding sync tracking, flush and post-sync write
//
// Decided for this implementation: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
`include "gpsc_defs.svh"
module gpsc_top import gpsc_pkg::*; #(
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Pipe status from the render pipe
  input  wire logic        pipe_busy,
  input  wire logic        ro_reads_pending,
  input  wire logic        nonblend_reads_pending,
  input  wire logic        media_busy,
  input  wire logic        depth_tests_pending,
  input  wire logic        pixel_visible_inc,
  input  wire logic        topology_change,
  input  wire logic        flush_ack,
  input  wire logic        context_save,
  // Cache and pipe controls
  output logic             ro_cache_inv,
  output logic             vf_cache_inv,
  output logic             index_cache_flush,
  output logic             render_flush_req,
  output logic             depth_flush_req,
  output logic             depth_stall_hold,
  output logic             parse_stall,
  output logic             skip_ptr_restore,
  // Memory write port
  output logic             mem_wr_valid,
  output logic      [63:0] mem_wr_data,
  input  wire logic        mem_wr_ready,
  // Completion
  output logic             sync_irq
);
  gpsc_queue_if qi ();
  gpsc_sync_queue #(.DEPTH(DEPTH)) u_queue (.clock(clock), .rst_n(rst_n), .q(qi.queue));

  function automatic logic [3:0] gpsc_limit(input logic media, input logic rev_a);
    gpsc_limit = media ? 4'h1 : (rev_a ? `GPSC_MAX_OUT_A : `GPSC_MAX_OUT);
  endfunction

  // ==========================================================
  // AHB-Lite slave
  logic        aph_wr_reg;
  logic [7:0]  aph_addr_reg;
  logic        cmd_go;
  logic [31:0] imm_lo_reg;
  logic [31:0] imm_hi_reg;
  logic [31:0] config_reg;
  logic [63:0] pix_cnt_reg;
  logic [63:0] time_cnt_reg;
  logic        fence_open_reg;
  gpsc_state_t st_reg;
  logic [31:0] rd_next;
  logic        xfer;
  logic        media_sel;
  logic        rev_a;

  assign xfer      = hsel & hready & htrans[1];
  assign media_sel = config_reg[0];
  assign rev_a     = config_reg[1];
  // Software may only issue when the parser is not stalled
  assign cmd_go    = aph_wr_reg & (aph_addr_reg == `GPSC_CMD_OFF);

  // Address phase capture
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      aph_wr_reg   <= 1'b0;
      aph_addr_reg <= 8'h00;
    end else if (hready) begin
      aph_wr_reg   <= xfer & hwrite;
      aph_addr_reg <= xfer ? haddr[7:0] : 8'h00;
    end
  end

  // No bus wait: hreadyout stays high and hresp stays low, even for a command write while parsing is stalled
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // Data registers written by software
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      imm_lo_reg <= 32'h00000000;
      imm_hi_reg <= 32'h00000000;
      config_reg <= `GPSC_CFG_RESET;
    end else if (aph_wr_reg) begin
      case (aph_addr_reg)
        `GPSC_IMM_LO_OFF: imm_lo_reg <= hwdata;
        `GPSC_IMM_HI_OFF: imm_hi_reg <= hwdata;
        `GPSC_CONFIG_OFF: config_reg <= {29'h0, hwdata[2:0]};
        default: ;
      endcase
    end
  end

  // Read mux
  always_comb begin
    case (haddr[7:0])
      `GPSC_STATUS_OFF: rd_next = {22'h0, fence_open_reg, ro_reads_pending, parse_stall, 3'h0, qi.count};
      `GPSC_PIXLO_OFF:  rd_next = pix_cnt_reg[31:0];
      `GPSC_PIXHI_OFF:  rd_next = pix_cnt_reg[63:32];
      `GPSC_TIMLO_OFF:  rd_next = time_cnt_reg[31:0];
      `GPSC_TIMHI_OFF:  rd_next = time_cnt_reg[63:32];
      `GPSC_CONFIG_OFF: rd_next = config_reg;
      default:          rd_next = 32'h00000000;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      hrdata <= 32'h00000000;
    end else if (xfer & ~hwrite) begin
      hrdata <= rd_next;
    end
  end

  // ==========================================================
  // Command parse and outstanding limit
  gpsc_cmd_t new_cmd;
  always_comb begin
    new_cmd        = '0;
    new_cmd.stall  = hwdata[`GPSC_B_STALL];
    new_cmd.dstall = hwdata[`GPSC_B_DSTALL];
    new_cmd.wflush = hwdata[`GPSC_B_WFLUSH];
    new_cmd.dflush = hwdata[`GPSC_B_DFLUSH];
    new_cmd.roinv  = hwdata[`GPSC_B_ROINV];
    new_cmd.vfinv  = hwdata[`GPSC_B_VFINV];
    new_cmd.irq    = hwdata[`GPSC_B_IRQ];
    new_cmd.memvis = hwdata[`GPSC_B_MEMVIS];
    new_cmd.op     = gpsc_op_t'(hwdata[`GPSC_B_OP +: 2]);
    new_cmd.imm    = {imm_hi_reg, imm_lo_reg};
  end

  assign qi.push     = cmd_go & ~parse_stall;
  assign qi.push_cmd = new_cmd;

  // Parse stall: at limit, or a stalling command still outstanding
  logic stall_cmd_open_reg;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      stall_cmd_open_reg <= 1'b0;
    end else if (qi.push & new_cmd.stall) begin
      stall_cmd_open_reg <= 1'b1;
    end else if (qi.count == 4'h0) begin
      stall_cmd_open_reg <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      parse_stall <= 1'b0;
    end else begin
      parse_stall <= ((qi.count + {3'h0, qi.push} - {3'h0, qi.pop}) >= gpsc_limit(media_sel, rev_a))
                     | (qi.push & new_cmd.stall) | (stall_cmd_open_reg & (qi.count > {3'h0, qi.pop}));
    end
  end

  // Depth stall holds later primitives from a depth-stall sync until the sync queue is empty
  logic dstall_pending_reg;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      dstall_pending_reg <= 1'b0;
      depth_stall_hold   <= 1'b0;
    end else begin
      if (qi.push & new_cmd.dstall) begin
        dstall_pending_reg <= 1'b1;
      end else if (qi.count == 4'h0) begin
        dstall_pending_reg <= 1'b0;
      end
      depth_stall_hold <= (qi.push & new_cmd.dstall) | (dstall_pending_reg & (qi.count != 4'h0));
    end
  end

  // ==========================================================
  // Free running time counter and visible pixel event counter, both cleared only by reset
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pix_cnt_reg  <= 64'h0000000000000000;
      time_cnt_reg <= 64'h0000000000000000;
    end else begin
      time_cnt_reg <= time_cnt_reg + 64'h0000000000000001;
      if (pixel_visible_inc) begin
        pix_cnt_reg <= pix_cnt_reg + 64'h0000000000000001;
      end
    end
  end

  // Index cache flush at every topology change
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      index_cache_flush <= 1'b0;
    end else begin
      index_cache_flush <= topology_change;
    end
  end

  // ==========================================================
  // Retire engine for the oldest outstanding sync
  gpsc_cmd_t h;
  logic      drained;
  assign h = qi.head_cmd;
  assign drained = ~pipe_busy & ~depth_tests_pending & ~nonblend_reads_pending
                   & (~media_sel | ~media_busy);

  assign qi.pop = (st_reg == GPSC_DONE);

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      st_reg <= GPSC_IDLE;
    end else begin
      case (st_reg)
        GPSC_IDLE:  if (qi.head_valid) begin
          st_reg <= GPSC_DRAIN;
        end
        GPSC_DRAIN: if (drained & ~ro_reads_pending) begin
          st_reg <= (h.wflush | h.dflush | h.memvis) ? GPSC_FLUSH : (h.op != GPSC_OP_NONE ? GPSC_WRITE : GPSC_DONE);
        end
        GPSC_FLUSH: if (flush_ack) begin
          st_reg <= (h.op != GPSC_OP_NONE) ? GPSC_WRITE : GPSC_DONE;
        end
        GPSC_WRITE: if (mem_wr_valid & mem_wr_ready) begin
          st_reg <= GPSC_DONE;
        end
        GPSC_DONE:  st_reg <= GPSC_IDLE;
        default:    st_reg <= GPSC_IDLE;
      endcase
    end
  end

  // Fence status: open while any non-blend read is outstanding
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      fence_open_reg <= 1'b0;
    end else begin
      fence_open_reg <= nonblend_reads_pending;
    end
  end

  // Cache flush requests
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      render_flush_req <= 1'b0;
      depth_flush_req  <= 1'b0;
    end else begin
      render_flush_req <= (st_reg == GPSC_FLUSH) & (h.wflush | h.memvis) & ~flush_ack;
      depth_flush_req  <= (st_reg == GPSC_FLUSH) & h.dflush & ~flush_ack;
    end
  end

  // Invalidate pulses once read-only accesses have drained
  logic inv_fire;
  assign inv_fire = (st_reg == GPSC_DRAIN) & drained & ~ro_reads_pending;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ro_cache_inv <= 1'b0;
      vf_cache_inv <= 1'b0;
    end else begin
      ro_cache_inv <= inv_fire & h.roinv;
      vf_cache_inv <= inv_fire & h.vfinv;
    end
  end

  // Pointer restore suppression after invalidate before context save
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      skip_ptr_restore <= 1'b0;
    end else if (inv_fire & (h.roinv | h.vfinv)) begin
      skip_ptr_restore <= 1'b1;
    end else if (context_save) begin
      skip_ptr_restore <= 1'b0;
    end
  end

  // Post-sync write: value sampled at the moment the write starts
  logic wr_start;
  assign wr_start = ((st_reg == GPSC_DRAIN) & drained & ~ro_reads_pending & ~(h.wflush | h.dflush | h.memvis)
                    & (h.op != GPSC_OP_NONE)) | ((st_reg == GPSC_FLUSH) & flush_ack & (h.op != GPSC_OP_NONE));
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      mem_wr_valid <= 1'b0;
      mem_wr_data  <= 64'h0000000000000000;
    end else if (wr_start) begin
      mem_wr_valid <= 1'b1;
      case (h.op)
        GPSC_OP_IMM: mem_wr_data <= h.imm;
        GPSC_OP_PIX: mem_wr_data <= pix_cnt_reg;
        default:     mem_wr_data <= time_cnt_reg;
      endcase
    end else if (mem_wr_ready) begin
      mem_wr_valid <= 1'b0;
    end
  end

  // Completion interrupt pulse
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sync_irq <= 1'b0;
    end else begin
      sync_irq <= qi.pop & h.irq & config_reg[2];
    end
  end

  chk_limit_kept: assert property (@(posedge clock) disable iff (!rst_n)
    qi.count <= `GPSC_MAX_OUT) else $error("too many outstanding syncs");
  chk_media_one: assert property (@(posedge clock) disable iff (!rst_n)
    media_sel & (qi.count == 4'h1) & !qi.pop |=> parse_stall) else $error("media pipe not limited");
  chk_ro_inv_safe: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(ro_cache_inv) |-> !$past(ro_reads_pending)) else $error("invalidate while reads pending");
  chk_nowrite_none: assert property (@(posedge clock) disable iff (!rst_n)
    st_reg == GPSC_WRITE |-> h.op != GPSC_OP_NONE) else $error("write without op");
  chk_flush_before: assert property (@(posedge clock) disable iff (!rst_n)
    (st_reg == GPSC_FLUSH) & !flush_ack |=> st_reg != GPSC_DONE) else $error("done before flush");
  chk_drain_end: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(st_reg == GPSC_DONE) |-> !$past(pipe_busy) | (h.wflush | h.dflush | h.memvis | h.op != GPSC_OP_NONE))
    else $error("retired while busy");
  chk_time_runs: assert property (@(posedge clock) disable iff (!rst_n)
    $past(rst_n) |-> time_cnt_reg == $past(time_cnt_reg) + 64'h1) else $error("time counter stuck");
  chk_topo_flush: assert property (@(posedge clock) disable iff (!rst_n)
    topology_change |=> index_cache_flush) else $error("index cache not flushed");
endmodule

/* verilog/gpsc_defs.svh */
// Constants of the pipe sync control block
`ifndef GPSC_DEFS_SVH
`define GPSC_DEFS_SVH
// ==========================================================
// Register byte offsets
`define GPSC_CMD_OFF     8'h00
`define GPSC_IMM_LO_OFF  8'h04
`define GPSC_IMM_HI_OFF  8'h08
`define GPSC_STATUS_OFF  8'h0C
`define GPSC_PIXLO_OFF   8'h10
`define GPSC_PIXHI_OFF   8'h14
`define GPSC_TIMLO_OFF   8'h18
`define GPSC_TIMHI_OFF   8'h1C
`define GPSC_CONFIG_OFF  8'h20
// ==========================================================
// Command field positions
`define GPSC_B_STALL     0
`define GPSC_B_DSTALL    1
`define GPSC_B_WFLUSH    2
`define GPSC_B_DFLUSH    3
`define GPSC_B_ROINV     4
`define GPSC_B_VFINV     5
`define GPSC_B_IRQ       6
`define GPSC_B_MEMVIS    7
`define GPSC_B_OP        8
// ==========================================================
// Limits and reset values
`define GPSC_MAX_OUT     4'h8
`define GPSC_MAX_OUT_A   4'h7
`define GPSC_CFG_RESET   32'h00000000
`endif

/* verilog/gpsc_pkg.sv */
// Types of the pipe sync control block
package gpsc_pkg;
  typedef enum logic [1:0] {GPSC_OP_NONE, GPSC_OP_IMM, GPSC_OP_PIX, GPSC_OP_TIME} gpsc_op_t;
  typedef enum {GPSC_IDLE, GPSC_DRAIN, GPSC_FLUSH, GPSC_WRITE, GPSC_DONE} gpsc_state_t;
  typedef struct packed {
    logic       stall;
    logic       dstall;
    logic       wflush;
    logic       dflush;
    logic       roinv;
    logic       vfinv;
    logic       irq;
    logic       memvis;
    gpsc_op_t   op;
    logic [63:0] imm;
  } gpsc_cmd_t;
endpackage

/* verilog/gpsc_queue_if.sv */
// Carrier between sync queue and control
`timescale 1ns/1ps
interface gpsc_queue_if;
  import gpsc_pkg::*;
  logic      push;
  gpsc_cmd_t push_cmd;
  logic      pop;
  logic      head_valid;
  gpsc_cmd_t head_cmd;
  logic [3:0] count;
  modport ctrl (output push, push_cmd, pop, input head_valid, head_cmd, count);
  modport queue (input push, push_cmd, pop, output head_valid, head_cmd, count);
endinterface

/* verilog/gpsc_sync_queue.sv */
// In-order queue of outstanding sync commands
`timescale 1ns/1ps
module gpsc_sync_queue import gpsc_pkg::*; #(
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic   clock,
  input wire logic   rst_n,
  // Queue side
  gpsc_queue_if.queue q
);
  gpsc_cmd_t  mem_reg [DEPTH];
  logic [2:0] wr_reg;
  logic [2:0] rd_reg;
  logic [3:0] cnt_reg;

  // Storage and pointers; entries leave oldest first
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wr_reg  <= 3'h0;
      rd_reg  <= 3'h0;
      cnt_reg <= 4'h0;
    end else begin
      if (q.push) begin
        mem_reg[wr_reg] <= q.push_cmd;
        wr_reg <= wr_reg + 3'h1;
      end
      if (q.pop) begin
        rd_reg <= rd_reg + 3'h1;
      end
      cnt_reg <= cnt_reg + {3'h0, q.push} - {3'h0, q.pop};
    end
  end

  assign q.head_valid = (cnt_reg != 4'h0);
  assign q.head_cmd   = mem_reg[rd_reg];
  assign q.count      = cnt_reg;
endmodule

/* verification/gpsc_pipe_model.sv */
// Render pipe and memory model facing the sync control block
`timescale 1ns/1ps
module gpsc_pipe_model (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // Controls from the bench
  input  wire logic        hold_busy,
  input  wire logic [1:0]  slow,
  // Pipe status and flush handshake
  output logic             pipe_busy,
  input  wire logic        render_flush_req,
  input  wire logic        depth_flush_req,
  output logic             flush_ack,
  // Memory write port
  input  wire logic        mem_wr_valid,
  input  wire logic [63:0] mem_wr_data,
  output logic             mem_wr_ready,
  // Stores seen at the memory side
  output int               wr_count,
  output logic      [63:0] last_data
);
  logic [1:0] fl_cnt;
  logic [1:0] wr_cnt;
  logic       fl_req;

  // Busy follows the bench so work can be kept in flight
  assign pipe_busy = hold_busy;
  assign fl_req    = render_flush_req | depth_flush_req;

  // Flush acknowledge after a wait of slow cycles, one pulse per request
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      flush_ack <= 1'b0;
      fl_cnt    <= 2'h0;
    end else begin
      flush_ack <= fl_req & ~flush_ack & (fl_cnt >= slow);
      fl_cnt    <= (fl_req & ~flush_ack) ? fl_cnt + 2'h1 : 2'h0;
    end
  end

  // Memory accepts a store after a wait of slow cycles and records it
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      mem_wr_ready <= 1'b0;
      wr_cnt       <= 2'h0;
      wr_count     <= 0;
      last_data    <= 64'h0;
    end else if (mem_wr_valid && mem_wr_ready) begin
      mem_wr_ready <= 1'b0;
      wr_cnt       <= 2'h0;
      wr_count     <= wr_count + 1;
      last_data    <= mem_wr_data;
    end else if (mem_wr_valid) begin
      mem_wr_ready <= (wr_cnt >= slow);
      wr_cnt       <= wr_cnt + 2'h1;
    end
  end
endmodule

/* verification/gpsc_top_bench.sv */
// Self-checking bench of the pipe sync control block
`timescale 1ns/1ps
`include "gpsc_defs.svh"
module gpsc_top_bench;
  // ==========================================================
  // Signals
  logic        clock;
  logic        rst_n;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  wire  [31:0] hrdata;
  wire         hreadyout, hresp, hready;
  logic        ro_reads_pending, nonblend_reads_pending, media_busy, depth_tests_pending;
  logic        pixel_visible_inc, topology_change, context_save, hold_busy;
  logic [1:0]  slow;
  wire         pipe_busy, flush_ack, mem_wr_ready, mem_wr_valid, sync_irq;
  wire         ro_cache_inv, vf_cache_inv, index_cache_flush, render_flush_req, depth_flush_req;
  wire         depth_stall_hold, parse_stall, skip_ptr_restore;
  wire  [63:0] mem_wr_data;
  logic [63:0] last_data;
  int          wr_count;
  int          fails, comparisons, cycles, irq_n, ro_n, vf_n, idx_n, ord_bad;

  assign hready = hreadyout;

  // ==========================================================
  // Design and partner
  gpsc_top #(.DEPTH(8)) gpsc_top_inst (
    .clock, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout,
    .hresp, .pipe_busy, .ro_reads_pending, .nonblend_reads_pending, .media_busy, .depth_tests_pending,
    .pixel_visible_inc, .topology_change, .flush_ack, .context_save, .ro_cache_inv, .vf_cache_inv,
    .index_cache_flush, .render_flush_req, .depth_flush_req, .depth_stall_hold, .parse_stall,
    .skip_ptr_restore, .mem_wr_valid, .mem_wr_data, .mem_wr_ready, .sync_irq);
  gpsc_pipe_model gpsc_pipe_model_inst (
    .clock, .rst_n, .hold_busy, .slow, .pipe_busy, .render_flush_req, .depth_flush_req, .flush_ack,
    .mem_wr_valid, .mem_wr_data, .mem_wr_ready, .wr_count, .last_data);

  // Clock of 10 ns
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // Pulse counters, store order watch and run limit
  always @(posedge clock) begin
    irq_n += int'(sync_irq === 1'b1);
    ro_n += int'(ro_cache_inv === 1'b1);
    vf_n += int'(vf_cache_inv === 1'b1);
    idx_n += int'(index_cache_flush === 1'b1);
    ord_bad += int'(mem_wr_valid === 1'b1 && (render_flush_req === 1'b1 || depth_flush_req === 1'b1));
    cycles++;
    if (cycles == 60000) begin
      fails++;
      stop_test();
    end
  end

  // ==========================================================
  // Tasks and expectations
  task automatic stop_test();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input bit ok, input string msg);
    comparisons++;
    if (!ok) begin
      fails++;
      $display("mismatch %0t %s", $time, msg);
    end
  endtask

  // One AHB-Lite single word transfer, read data taken at the data phase edge
  task automatic bus(input bit wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clock);
    haddr  <= {24'h000000, a};
    htrans <= 2'b10;
    hwrite <= wr;
    @(posedge clock);
    while (hready !== 1'b1) @(posedge clock);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge clock);
    while (hready !== 1'b1) @(posedge clock);
    q = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  // Poll the queue count until every sync has retired
  task automatic idle();
    logic [31:0] s;
    int          n;
    n = 0;
    do begin
      bus(1'b0, `GPSC_STATUS_OFF, 32'h0, s);
      n++;
    end while (s[3:0] !== 4'h0 && n < 200);
    check(s[3:0] === 4'h0, "sync queue did not drain");
    repeat (2) @(posedge clock);
  endtask

  function automatic logic [31:0] mk(input logic [7:0] bits, input logic [1:0] op);
    return {22'h0, op, bits};
  endfunction

  function automatic int lim(input logic [31:0] cfg);
    return cfg[0] ? 1 : (cfg[1] ? 7 : 8);
  endfunction

  // ==========================================================
  // Main sequence
  initial begin
    logic [31:0] s, cfg, seed;
    logic [63:0] imm, t0, total;
    int          n, w, r, v;
    rst_n = 1'b0; hsel = 1'b1; haddr = 32'h0; htrans = 2'b00; hwrite = 1'b0; hsize = 3'h2; hwdata = 32'h0;
    ro_reads_pending = 1'b0; nonblend_reads_pending = 1'b0; media_busy = 1'b0; depth_tests_pending = 1'b0;
    pixel_visible_inc = 1'b0; topology_change = 1'b0; context_save = 1'b0; hold_busy = 1'b0; slow = 2'h0;
    total = 64'h0;
    seed = $urandom(77);
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    // Reset values and an unmapped place
    bus(1'b0, `GPSC_STATUS_OFF, 32'h0, s);
    check(s === 32'h0 && hresp === 1'b0, "status after reset");
    bus(1'b0, `GPSC_CONFIG_OFF, 32'h0, s);
    check(s === `GPSC_CFG_RESET, "config after reset");
    wr(8'h40, 32'hFFFFFFFF);
    bus(1'b0, 8'h40, 32'h0, s);
    check(s === 32'h0, "unmapped read not zero");
    // Outstanding limit for each pipe setting
    for (int k = 0; k < 3; k++) begin
      cfg = (k == 0) ? 32'h0 : ((k == 1) ? 32'h2 : 32'h1);
      wr(`GPSC_CONFIG_OFF, cfg);
      hold_busy <= 1'b1;
      media_busy <= 1'b1;
      for (int i = 0; i < lim(cfg); i++) begin
        bus(1'b0, `GPSC_STATUS_OFF, 32'h0, s);
        check(s[7] === 1'b0, "parse stalled below limit");
        wr(`GPSC_CMD_OFF, mk(8'h00, 2'b00));
      end
      bus(1'b0, `GPSC_STATUS_OFF, 32'h0, s);
      check(s[3:0] === 4'(lim(cfg)) && s[7] === 1'b1, "limit count or stall");
      hold_busy <= 1'b0;
      media_busy <= 1'b0;
      idle();
      check(parse_stall === 1'b0, "stall kept after retire");
    end
    // Media pipe waits for the media units
    wr(`GPSC_CONFIG_OFF, 32'h1);
    media_busy <= 1'b1;
    w = wr_count;
    wr(`GPSC_CMD_OFF, mk(8'h00, 2'b01));
    repeat (20) @(posedge clock);
    check(wr_count == w, "media sync stored early");
    media_busy <= 1'b0;
    idle();
    check(wr_count == w + 1, "media sync store missing");
    wr(`GPSC_CONFIG_OFF, 32'h0);
    // Random immediates behind render and depth flushes, partner at random speed
    for (int i = 0; i < 4; i++) begin
      slow <= 2'($urandom % 4);
      imm = {$urandom, $urandom};
      wr(`GPSC_IMM_LO_OFF, imm[31:0]);
      wr(`GPSC_IMM_HI_OFF, imm[63:32]);
      w = wr_count;
      wr(`GPSC_CMD_OFF, mk(i[0] ? 8'h80 : 8'h0C, 2'b01));
      idle();
      check(wr_count == w + 1 && last_data === imm, "immediate store");
      check(ord_bad == 0, "store before flush done");
    end
    // Flush only, no store
    w = wr_count;
    wr(`GPSC_CMD_OFF, mk(8'h04, 2'b00));
    idle();
    check(wr_count == w, "store with no operation");
    // Pixel count with depth stall
    hold_busy <= 1'b1;
    depth_tests_pending <= 1'b1;
    n = 1 + int'($urandom % 20);
    repeat (n) begin
      @(posedge clock);
      pixel_visible_inc <= 1'b1;
      @(posedge clock);
      pixel_visible_inc <= 1'b0;
    end
    total = total + 64'(n);
    wr(`GPSC_CMD_OFF, mk(8'h02, 2'b10));
    repeat (4) @(posedge clock);
    check(depth_stall_hold === 1'b1, "depth stall not held");
    hold_busy <= 1'b0;
    depth_tests_pending <= 1'b0;
    idle();
    check(last_data === total, "pixel count stored");
    check(depth_stall_hold === 1'b0, "depth stall not released");
    bus(1'b0, `GPSC_PIXLO_OFF, 32'h0, s);
    check(s === total[31:0], "pixel counter cleared by sync");
    // Two time stores must grow
    wr(`GPSC_CMD_OFF, mk(8'h00, 2'b11));
    idle();
    t0 = last_data;
    wr(`GPSC_CMD_OFF, mk(8'h00, 2'b11));
    idle();
    check(last_data > t0 && t0 !== 64'h0, "time counter not running");
    // Interrupt enabled then disabled
    for (int e = 0; e < 2; e++) begin
      wr(`GPSC_CONFIG_OFF, (e == 0) ? 32'h4 : 32'h0);
      v = irq_n;
      wr(`GPSC_CMD_OFF, mk(8'h40, 2'b00));
      idle();
      check(irq_n == v + ((e == 0) ? 1 : 0), "completion interrupt count");
    end
    // Read-only invalidate waits for pending reads
    ro_reads_pending <= 1'b1;
    nonblend_reads_pending <= 1'b1;
    r = ro_n;
    v = vf_n;
    wr(`GPSC_CMD_OFF, mk(8'h10, 2'b00));
    repeat (10) @(posedge clock);
    check(ro_n == r, "invalidate while reads pending");
    bus(1'b0, `GPSC_STATUS_OFF, 32'h0, s);
    check(s[8] === 1'b1 && s[9] === 1'b1 && s[3:0] === 4'h1, "read fence closed early");
    ro_reads_pending <= 1'b0;
    nonblend_reads_pending <= 1'b0;
    idle();
    check(ro_n == r + 1 && vf_n == v, "read-only invalidate");
    check(skip_ptr_restore === 1'b1, "pointer restore not skipped");
    @(posedge clock);
    context_save <= 1'b1;
    @(posedge clock);
    context_save <= 1'b0;
    repeat (2) @(posedge clock);
    check(skip_ptr_restore === 1'b0, "skip kept after save");
    wr(`GPSC_CMD_OFF, mk(8'h20, 2'b00));
    idle();
    check(vf_n == v + 1 && ro_n == r + 1, "vertex invalidate");
    // Stall bit holds parsing
    hold_busy <= 1'b1;
    wr(`GPSC_CMD_OFF, mk(8'h01, 2'b00));
    repeat (2) @(posedge clock);
    check(parse_stall === 1'b1, "stall bit ignored");
    hold_busy <= 1'b0;
    idle();
    check(parse_stall === 1'b0, "stall not released");
    // Stalling pair around six immediate register writes, as a table invalidate needs
    w = wr_count;
    wr(`GPSC_CMD_OFF, mk(8'h01, 2'b00));
    idle();
    repeat (6) begin
      imm[31:0] = $urandom;
      wr(`GPSC_IMM_LO_OFF, imm[31:0]);
    end
    wr(`GPSC_CMD_OFF, mk(8'h01, 2'b01));
    idle();
    check(wr_count == w + 1 && last_data === imm && parse_stall === 1'b0, "stalling pair store");
    // Topology change flushes the index cache
    v = idx_n;
    @(posedge clock);
    topology_change <= 1'b1;
    @(posedge clock);
    topology_change <= 1'b0;
    repeat (3) @(posedge clock);
    check(idx_n == v + 1, "index cache not flushed");
    stop_test();
  end
endmodule
